// ===== verilog/sigmod_pkg.sv
package sigmod_pkg;
    // Modulator source select encodings
    localparam logic [3:0] MOD_SEL_PROG = 4'h0;
    localparam logic [3:0] MOD_SEL_PIN = 4'h1;
    localparam logic [3:0] MOD_SEL_CCP = 4'h2;
    localparam logic [3:0] MOD_SEL_CMP1 = 4'h3;
    localparam logic [3:0] MOD_SEL_CMP2 = 4'h4;
    localparam logic [3:0] MOD_SEL_UART = 4'h5;
    localparam logic [3:0] MOD_SEL_SPI = 4'h6;
    // Carrier source select encodings
    localparam logic [3:0] CAR_SEL_GND = 4'h0;
    localparam logic [3:0] CAR_SEL_PIN_A = 4'h1;
    localparam logic [3:0] CAR_SEL_PIN_B = 4'h2;
    localparam logic [3:0] CAR_SEL_REFCLK = 4'h3;
    localparam logic [3:0] CAR_SEL_CCP = 4'h4;
    // Reset values of the output controls
    localparam logic SLEW_RESET = 1'b1;
    localparam logic LOW_RESET = 1'b0;
    // Active carrier choice
    typedef enum logic {SIGMOD_CAR_LOW, SIGMOD_CAR_HIGH} sigmod_car_t;
endpackage

// ===== verilog/sigmod_core.sv
`timescale 1ns/1ps
`default_nettype none
module sigmod_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control bits
    input wire logic moduleEnableBit,
    input wire logic outputEnableBit,
    input wire logic slewLimitEnable,
    input wire logic outputInvert,
    input wire logic programmedModulatorValue,
    input wire logic [3:0] modulatorSourceSelect,
    input wire logic modulatorPinDetach,
    input wire logic [3:0] carrierHighSelect,
    input wire logic carrierHighSyncEnable,
    input wire logic carrierHighInvert,
    input wire logic carrierHighPinDetach,
    input wire logic [3:0] carrierLowSelect,
    input wire logic carrierLowSyncEnable,
    input wire logic carrierLowInvert,
    input wire logic carrierLowPinDetach,
    // On-chip sources, same clock
    input wire logic ccpOut,
    input wire logic spiSerialOut,
    input wire logic comparator1Out,
    input wire logic comparator2Out,
    input wire logic uartTx,
    input wire logic refClockOut,
    // External pins
    input wire logic externalModulatorIn,
    input wire logic externalCarrierInA,
    input wire logic externalCarrierInB,
    // Outputs
    output logic modulatedOutputPin,
    output logic slewLimitPad,
    output logic modulatedOutputStatus,
    output logic ccpPinDetach,
    output logic spiPinDetach,
    output logic uartPinDetach,
    output logic refClockPinDetach
);

    // Three-stage pin synchronizers
    logic [2:0] modPinSync_q;
    logic [2:0] carAPinSync_q;
    logic [2:0] carBPinSync_q;
    logic modPin_q;
    logic carAPin_q;
    logic carBPin_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            modPinSync_q <= 3'h0;
            carAPinSync_q <= 3'h0;
            carBPinSync_q <= 3'h0;
        end else begin
            modPinSync_q <= {modPinSync_q[1:0], externalModulatorIn};
            carAPinSync_q <= {carAPinSync_q[1:0], externalCarrierInA};
            carBPinSync_q <= {carBPinSync_q[1:0], externalCarrierInB};
        end
    end

    // Accept a pin change once stages two and three agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            modPin_q <= 1'b0;
            carAPin_q <= 1'b0;
            carBPin_q <= 1'b0;
        end else begin
            if (modPinSync_q[1] == modPinSync_q[2]) modPin_q <= modPinSync_q[2];
            if (carAPinSync_q[1] == carAPinSync_q[2]) carAPin_q <= carAPinSync_q[2];
            if (carBPinSync_q[1] == carBPinSync_q[2]) carBPin_q <= carBPinSync_q[2];
        end
    end

    // Carrier source mux
    function automatic logic carrierMux(input logic [3:0] sel, input logic ccp,
                                        input logic refc, input logic pa, input logic pb);
        case (sel)
            sigmod_pkg::CAR_SEL_CCP: carrierMux = ccp;
            sigmod_pkg::CAR_SEL_REFCLK: carrierMux = refc;
            sigmod_pkg::CAR_SEL_PIN_A: carrierMux = pa;
            sigmod_pkg::CAR_SEL_PIN_B: carrierMux = pb;
            default: carrierMux = 1'b0;
        endcase
    endfunction

    // Source selection; carriers forced quiet while disabled, modulator falls back to the programmed value
    logic modSel;
    logic carHighRaw;
    logic carLowRaw;
    logic carHigh;
    logic carLow;
    logic modulator;

    always_comb begin
        case (modulatorSourceSelect)
            sigmod_pkg::MOD_SEL_PROG: modSel = programmedModulatorValue;
            sigmod_pkg::MOD_SEL_PIN: modSel = modPin_q;
            sigmod_pkg::MOD_SEL_CCP: modSel = ccpOut;
            sigmod_pkg::MOD_SEL_CMP1: modSel = comparator1Out;
            sigmod_pkg::MOD_SEL_CMP2: modSel = comparator2Out;
            sigmod_pkg::MOD_SEL_UART: modSel = uartTx;
            sigmod_pkg::MOD_SEL_SPI: modSel = spiSerialOut;
            default: modSel = 1'b0;
        endcase
    end

    // Selections are inputs only, never cleared by disable
    assign carHighRaw = carrierMux(carrierHighSelect, ccpOut, refClockOut,
                                   carAPin_q, carBPin_q);
    assign carLowRaw = carrierMux(carrierLowSelect, ccpOut, refClockOut,
                                  carAPin_q, carBPin_q);
    assign carHigh = moduleEnableBit & (carHighRaw ^ carrierHighInvert);
    assign carLow = moduleEnableBit & (carLowRaw ^ carrierLowInvert);
    assign modulator = moduleEnableBit ? modSel : programmedModulatorValue;

    // Active carrier tracking with pulse-end synchronization
    sigmod_pkg::sigmod_car_t active_q;
    sigmod_pkg::sigmod_car_t active_d;
    logic activeCarrier;
    logic wantHigh;

    assign wantHigh = modulator;

    always_comb begin
        active_d = active_q;
        case (active_q)
            sigmod_pkg::SIGMOD_CAR_HIGH: begin
                if (!wantHigh && (!carrierHighSyncEnable || !carHigh)) begin
                    active_d = sigmod_pkg::SIGMOD_CAR_LOW;
                end
            end
            sigmod_pkg::SIGMOD_CAR_LOW: begin
                if (wantHigh && (!carrierLowSyncEnable || !carLow)) begin
                    active_d = sigmod_pkg::SIGMOD_CAR_HIGH;
                end
            end
            default: active_d = sigmod_pkg::SIGMOD_CAR_LOW;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            active_q <= sigmod_pkg::SIGMOD_CAR_LOW;
        end else begin
            active_q <= active_d;
        end
    end

    // Carrier in use this cycle: switch at once when no sync holds it
    assign activeCarrier = (active_d == sigmod_pkg::SIGMOD_CAR_HIGH) ? carHigh : carLow;

    // Mixing, polarity, gating; no sleep input so it keeps running
    logic mixed;
    logic pinNext;

    assign mixed = activeCarrier;
    assign pinNext = outputEnableBit & (mixed ^ outputInvert);

    // Registered outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            modulatedOutputPin <= sigmod_pkg::LOW_RESET;
            modulatedOutputStatus <= sigmod_pkg::LOW_RESET;
            slewLimitPad <= sigmod_pkg::SLEW_RESET;
        end else begin
            modulatedOutputPin <= pinNext;
            modulatedOutputStatus <= mixed ^ outputInvert;
            slewLimitPad <= slewLimitEnable;
        end
    end

    // Pin detach requests to the selected source peripherals
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ccpPinDetach <= 1'b0;
            spiPinDetach <= 1'b0;
            uartPinDetach <= 1'b0;
            refClockPinDetach <= 1'b0;
        end else begin
            ccpPinDetach <= (modulatorPinDetach
                             && modulatorSourceSelect == sigmod_pkg::MOD_SEL_CCP)
                || (carrierHighPinDetach
                    && carrierHighSelect == sigmod_pkg::CAR_SEL_CCP)
                || (carrierLowPinDetach
                    && carrierLowSelect == sigmod_pkg::CAR_SEL_CCP);
            spiPinDetach <= modulatorPinDetach
                && modulatorSourceSelect == sigmod_pkg::MOD_SEL_SPI;
            uartPinDetach <= modulatorPinDetach
                && modulatorSourceSelect == sigmod_pkg::MOD_SEL_UART;
            refClockPinDetach <= (carrierHighPinDetach
                                  && carrierHighSelect == sigmod_pkg::CAR_SEL_REFCLK)
                || (carrierLowPinDetach
                    && carrierLowSelect == sigmod_pkg::CAR_SEL_REFCLK);
        end
    end

    // Checks
    property p_disabled_low;
        @(posedge clk) disable iff (!rstn)
        !moduleEnableBit && !outputInvert |=> !modulatedOutputPin;
    endproperty
    a_disabled_low: assert property (p_disabled_low)
        else $error("output toggled while disabled");

    property p_oe_low;
        @(posedge clk) disable iff (!rstn)
        !outputEnableBit |=> !modulatedOutputPin;
    endproperty
    a_oe_low: assert property (p_oe_low) else $error("pin high with output disabled");

    property p_pin_follows;
        @(posedge clk) disable iff (!rstn)
        outputEnableBit |=> modulatedOutputPin == $past(mixed ^ outputInvert);
    endproperty
    a_pin_follows: assert property (p_pin_follows) else $error("pin not mix value");

    property p_slew;
        @(posedge clk) disable iff (!rstn)
        1'b1 |=> slewLimitPad == $past(slewLimitEnable);
    endproperty
    a_slew: assert property (p_slew) else $error("slew pad mismatch");

    property p_high_sync_hold;
        @(posedge clk) disable iff (!rstn)
        active_q == sigmod_pkg::SIGMOD_CAR_HIGH && carrierHighSyncEnable && carHigh
            |=> active_q == sigmod_pkg::SIGMOD_CAR_HIGH;
    endproperty
    a_high_sync_hold: assert property (p_high_sync_hold)
        else $error("left high mid-pulse");

    property p_low_sync_hold;
        @(posedge clk) disable iff (!rstn)
        active_q == sigmod_pkg::SIGMOD_CAR_LOW && carrierLowSyncEnable && carLow
            |=> active_q == sigmod_pkg::SIGMOD_CAR_LOW;
    endproperty
    a_low_sync_hold: assert property (p_low_sync_hold) else $error("left low mid-pulse");

    property p_nosync_switch;
        @(posedge clk) disable iff (!rstn)
        !carrierHighSyncEnable && !carrierLowSyncEnable
            |-> (active_d == sigmod_pkg::SIGMOD_CAR_HIGH) == modulator;
    endproperty
    a_nosync_switch: assert property (p_nosync_switch)
        else $error("carrier not per modulator");

    property p_prog_mod;
        @(posedge clk) disable iff (!rstn)
        !moduleEnableBit |-> modulator == programmedModulatorValue;
    endproperty
    a_prog_mod: assert property (p_prog_mod) else $error("modulator not programmed bit");

    // Checks on carrier choice, detach requests, pin filtering and the status output
    property p_car_quiet;
        @(posedge clk) disable iff (!rstn)
        !moduleEnableBit |-> !carHigh && !carLow;
    endproperty
    a_car_quiet: assert property (p_car_quiet) else $error("carrier on while off");

    property p_high_free;
        @(posedge clk) disable iff (!rstn)
        active_q == sigmod_pkg::SIGMOD_CAR_HIGH && !wantHigh && !carHigh
            |=> active_q == sigmod_pkg::SIGMOD_CAR_LOW;
    endproperty
    a_high_free: assert property (p_high_free) else $error("stuck on high carrier");

    property p_low_free;
        @(posedge clk) disable iff (!rstn)
        active_q == sigmod_pkg::SIGMOD_CAR_LOW && wantHigh && !carLow
            |=> active_q == sigmod_pkg::SIGMOD_CAR_HIGH;
    endproperty
    a_low_free: assert property (p_low_free) else $error("stuck on low carrier");

    property p_high_nosync;
        @(posedge clk) disable iff (!rstn)
        active_q == sigmod_pkg::SIGMOD_CAR_HIGH && !carrierHighSyncEnable && !wantHigh
            |=> active_q == sigmod_pkg::SIGMOD_CAR_LOW;
    endproperty
    a_high_nosync: assert property (p_high_nosync) else $error("high carrier held");

    property p_low_nosync;
        @(posedge clk) disable iff (!rstn)
        active_q == sigmod_pkg::SIGMOD_CAR_LOW && !carrierLowSyncEnable && wantHigh
            |=> active_q == sigmod_pkg::SIGMOD_CAR_HIGH;
    endproperty
    a_low_nosync: assert property (p_low_nosync) else $error("low carrier held");

    property p_detach_off;
        @(posedge clk) disable iff (!rstn)
        !modulatorPinDetach && !carrierHighPinDetach && !carrierLowPinDetach
            |=> !ccpPinDetach && !spiPinDetach && !uartPinDetach && !refClockPinDetach;
    endproperty
    a_detach_off: assert property (p_detach_off) else $error("stray detach");

    property p_spi_det;
        @(posedge clk) disable iff (!rstn)
        modulatorPinDetach && modulatorSourceSelect == sigmod_pkg::MOD_SEL_SPI
            |=> spiPinDetach;
    endproperty
    a_spi_det: assert property (p_spi_det) else $error("serial pin kept");

    property p_uart_det;
        @(posedge clk) disable iff (!rstn)
        modulatorPinDetach && modulatorSourceSelect == sigmod_pkg::MOD_SEL_UART
            |=> uartPinDetach;
    endproperty
    a_uart_det: assert property (p_uart_det) else $error("transmit pin kept");

    property p_rck_det;
        @(posedge clk) disable iff (!rstn)
        carrierLowPinDetach && carrierLowSelect == sigmod_pkg::CAR_SEL_REFCLK
            |=> refClockPinDetach;
    endproperty
    a_rck_det: assert property (p_rck_det) else $error("clock pin kept");

    property p_mod_filter;
        @(posedge clk) disable iff (!rstn)
        modPinSync_q[1] != modPinSync_q[2] |=> $stable(modPin_q);
    endproperty
    a_mod_filter: assert property (p_mod_filter) else $error("pin taken unsettled");

    property p_status_gate;
        @(posedge clk) disable iff (!rstn)
        outputEnableBit |=> modulatedOutputPin == modulatedOutputStatus;
    endproperty
    a_status_gate: assert property (p_status_gate) else $error("pin differs from mix");

endmodule // sigmod_core
`default_nettype wire

// ===== sim/sigmod_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module sigmod_src_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Levels asked of the sources
    input wire logic [8:0] level,
    // Source outputs
    output logic ccpOut,
    output logic spiSerialOut,
    output logic comparator1Out,
    output logic comparator2Out,
    output logic uartTx,
    output logic refClockOut,
    output logic externalModulatorIn,
    output logic externalCarrierInA,
    output logic externalCarrierInB
);
    logic [8:0] src_q;
    // Sources only move on the clock edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            src_q <= 9'h000;
        end else begin
            src_q <= level;
        end
    end
    // Fan out to the individual sources
    assign {externalCarrierInB, externalCarrierInA, externalModulatorIn, refClockOut, uartTx,
            comparator2Out, comparator1Out, spiSerialOut, ccpOut} = src_q;
endmodule // sigmod_src_model
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rstn, en, oe, slew, oinv, prog, mDet, hSync, hInv, hDet, lSync, lInv, lDet;
    logic [3:0] mSel, hSel, lSel;
    logic [8:0] level;
    logic ccp, spi, c1, c2, utx, rck, eM, eA, eB, pin, pad, stat, dCcp, dSpi, dUart, dRck;
    int nFail = 0;
    int totalChecks = 0;
    int mIdx[7] = '{0, 6, 0, 2, 3, 4, 1};
    int cIdx[5] = '{0, 7, 8, 5, 0};
    sigmod_src_model i_sigmod_src_model (.clk(clk), .rstn(rstn), .level(level), .ccpOut(ccp),
        .spiSerialOut(spi), .comparator1Out(c1), .comparator2Out(c2), .uartTx(utx),
        .refClockOut(rck), .externalModulatorIn(eM), .externalCarrierInA(eA),
        .externalCarrierInB(eB));
    sigmod_core i_sigmod_core (.clk(clk), .rstn(rstn), .moduleEnableBit(en),
        .outputEnableBit(oe), .slewLimitEnable(slew), .outputInvert(oinv),
        .programmedModulatorValue(prog), .modulatorSourceSelect(mSel),
        .modulatorPinDetach(mDet), .carrierHighSelect(hSel), .carrierHighSyncEnable(hSync),
        .carrierHighInvert(hInv), .carrierHighPinDetach(hDet), .carrierLowSelect(lSel),
        .carrierLowSyncEnable(lSync), .carrierLowInvert(lInv), .carrierLowPinDetach(lDet),
        .ccpOut(ccp), .spiSerialOut(spi), .comparator1Out(c1), .comparator2Out(c2),
        .uartTx(utx), .refClockOut(rck), .externalModulatorIn(eM), .externalCarrierInA(eA),
        .externalCarrierInB(eB), .modulatedOutputPin(pin), .slewLimitPad(pad),
        .modulatedOutputStatus(stat), .ccpPinDetach(dCcp), .spiPinDetach(dSpi),
        .uartPinDetach(dUart), .refClockPinDetach(dRck));
    // Wait n edges, then settle
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Compare one output
    task automatic chk(input logic seen, input logic exp);
        totalChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("Error at %0t: saw %b, expected %b", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic endOfTest;
        $display("checks %0d, mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog
    initial begin
        #100000;
        nFail++;
        endOfTest();
    end
    // Tests
    initial begin
        {rstn, en, oe, oinv, prog, mDet, hSync, hInv, hDet, lSync, lInv, lDet} = '0;
        slew = 1'b1;
        {mSel, hSel, lSel} = '0;
        level = 9'h000;
        #12;
        chk(pin, 1'b0);
        chk(pad, 1'b1);
        @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        en <= 1'b1;
        oe <= 1'b1;
        hInv <= 1'b1;
        // Carrier high fixed at 1, low at 0: pin follows the modulator
        for (int c = 0; c < 7; c++) for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            mSel <= 4'(c);
            prog <= (c == 0) ? v[0] : !v[0];
            level <= v[0] ? (9'h001 << mIdx[c]) : ~(9'h001 << mIdx[c]);
            wt(8);
            chk(pin, v[0]);
        end
        // Each carrier source on its own, high then low
        for (int s = 0; s < 2; s++) for (int c = 0; c < 5; c++) for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            mSel <= sigmod_pkg::MOD_SEL_PROG;
            prog <= !s[0];
            hInv <= 1'b0;
            hSel <= s[0] ? 4'h0 : 4'(c);
            lSel <= s[0] ? 4'(c) : 4'h0;
            level <= v[0] ? (9'h001 << cIdx[c]) : ~(9'h001 << cIdx[c]);
            wt(8);
            chk(pin, c != 0 && v != 0);
        end
        // Disabled: carriers grounded, output only shows the invert; then enabled, output enable gates the pin but not the status
        @(posedge clk);
        level <= 9'h1ff;
        mSel <= sigmod_pkg::MOD_SEL_PIN;
        hSel <= sigmod_pkg::CAR_SEL_PIN_A;
        en <= 1'b0;
        wt(8);
        chk(pin, 1'b0);
        @(posedge clk);
        oinv <= 1'b1;
        wt(3);
        chk(pin, 1'b1);
        chk(stat, 1'b1);
        @(posedge clk);
        oinv <= 1'b0;
        en <= 1'b1;
        wt(8);
        chk(pin, 1'b1);
        @(posedge clk);
        oe <= 1'b0;
        wt(3);
        chk(pin, 1'b0);
        chk(stat, 1'b1);
        @(posedge clk);
        oinv <= 1'b1;
        wt(3);
        chk(pin, 1'b0);
        chk(stat, 1'b0);
        @(posedge clk);
        oe <= 1'b1;
        wt(3);
        chk(pin, 1'b0);
        // Carrier switch held until the pulse ends; high carrier 1, low 0
        @(posedge clk);
        oinv <= 1'b0;
        mSel <= sigmod_pkg::MOD_SEL_PROG;
        prog <= 1'b1;
        hSel <= sigmod_pkg::CAR_SEL_GND;
        hInv <= 1'b1;
        lSel <= sigmod_pkg::CAR_SEL_CCP;
        lInv <= 1'b1;
        hSync <= 1'b1;
        wt(3);
        chk(pin, 1'b1);
        @(posedge clk);
        prog <= 1'b0;
        wt(3);
        chk(pin, 1'b1);
        // High pulse ends while low carrier runs
        @(posedge clk);
        hInv <= 1'b0;
        lInv <= 1'b0;
        wt(3);
        chk(pin, 1'b1);
        // Low sync off: leave the low carrier at once
        @(posedge clk);
        prog <= 1'b1;
        wt(3);
        chk(pin, 1'b0);
        @(posedge clk);
        lSync <= 1'b1;
        prog <= 1'b0;
        wt(3);
        chk(pin, 1'b1);
        // Low sync on: low carrier kept while its pulse is high
        @(posedge clk);
        prog <= 1'b1;
        wt(3);
        chk(pin, 1'b1);
        @(posedge clk);
        hInv <= 1'b1;
        lInv <= 1'b1;
        wt(3);
        chk(pin, 1'b1);
        // High sync off: leave the high carrier mid-pulse
        @(posedge clk);
        hSync <= 1'b0;
        prog <= 1'b0;
        wt(3);
        chk(pin, 1'b0);
        // Pad slew and pin detach controls
        @(posedge clk);
        lSync <= 1'b0;
        slew <= 1'b0;
        hDet <= 1'b1;
        hSel <= sigmod_pkg::CAR_SEL_CCP;
        mDet <= 1'b1;
        mSel <= sigmod_pkg::MOD_SEL_SPI;
        wt(3);
        chk(pad, 1'b0);
        chk(dCcp, 1'b1);
        chk(dSpi, 1'b1);
        chk(dUart, 1'b0);
        chk(dRck, 1'b0);
        @(posedge clk);
        hDet <= 1'b0;
        lDet <= 1'b1;
        lSel <= sigmod_pkg::CAR_SEL_REFCLK;
        mSel <= sigmod_pkg::MOD_SEL_UART;
        wt(3);
        chk(dCcp, 1'b0);
        chk(dRck, 1'b1);
        chk(dUart, 1'b1);
        chk(dSpi, 1'b0);
        // Reset in mid-run restores the defaults
        @(posedge clk);
        rstn <= 1'b0;
        wt(1);
        chk(pad, 1'b1);
        chk(dRck, 1'b0);
        chk(dUart, 1'b0);
        @(posedge clk);
        {en, oe, prog, mDet, lDet} <= '0;
        slew <= 1'b1;
        @(posedge clk);
        rstn <= 1'b1;
        wt(3);
        chk(pad, 1'b1);
        chk(pin, 1'b0);
        endOfTest();
    end
endmodule // tb
`default_nettype wire
